//--- dhs_pkg.sv
// Package: sequencer_constant and types of the header search and write start block
`default_nettype none
package dhs_pkg;
  localparam int CLK_HZ     = 50_000_000; // System clock rate
  localparam int TIMEOUT_MS = 10;         // Function timer span, ms
  localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam logic [7:0]  SYNC_BYTE   = 8'h19;  // Header and data sync pattern
  localparam logic [6:0]  GLITCH_PLS  = 7'h3C;  // 60 servo pulses after sector
  localparam logic [6:0]  PHASE_PLS   = 7'h58;  // 88 servo pulses for lock
  localparam logic [6:0]  WG_DLY_PLS  = 7'h10;  // Read gate off to write gate
  localparam logic [6:0]  GAP_BITS    = 7'h78;  // 120 zero bits of header gap
  localparam logic [5:0]  HDR_LAST    = 6'h1F;  // 32 header bits
  localparam logic [5:0]  CRC_LAST    = 6'h0F;  // 16 header check bits
  localparam logic [5:0]  BYTE_LAST   = 6'h07;  // Bits 0..7 of a byte
  localparam logic [9:0]  DATA_BYTES  = 10'h200; // 512 bytes per sector
  localparam logic [31:0] HDR_MASK    = 32'h00FF_071F; // Address bits of header
  localparam logic [4:0]  SKIP_POS    = 5'h0E;  // Skip flag bit of header
  localparam logic [2:0]  FC_WRITE    = 3'h1;   // Write data function code
  localparam logic [1:0]  BUF_DEPTH   = 2'h2;   // Entries of the byte buffer
  // Sequencer steps
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_WSEC = 4'b0001, ST_GLITCH = 4'b0010,
    ST_PHASE = 4'b0011, ST_HUNT = 4'b0100, ST_HDR = 4'b0101,
    ST_CHECK = 4'b0110, ST_HCRC = 4'b0111, ST_CRCCMP = 4'b1000,
    ST_FIFO = 4'b1001, ST_WGDLY = 4'b1010, ST_GAP = 4'b1011,
    ST_SYNCO = 4'b1100, ST_DATA = 4'b1101
  } dhs_state_type;
  // Clock source selection
  typedef enum logic [1:0] {
    CK_CPU = 2'b00, CK_SERVO = 2'b01, CK_READ = 2'b10
  } dhs_clk_type;
  // Controls toward the check word logic
  typedef struct packed {
    logic clear;   // One-cycle pulse
    logic enable;  // Accumulate level
    logic load;    // Level while drive check bits arrive
    logic compare; // One-cycle pulse
  } dhs_crc_type;
  // Whole state of the block
  typedef struct packed {
    dhs_state_type   st;
    logic [1:0]      srv, rdc, rdd, sec; // Pin synchronisers
    logic            srv_p, rdc_p, sec_p;
    logic [6:0]      cnt;
    logic [5:0]      bits;
    logic [7:0]      shreg, sconst;
    logic [15:0]     dar;
    logic [2:0]      fc;
    logic            ie, inh, agree, skip;
    dhs_clk_type     cur, seq;
    logic            rgate, wgate, wdata, nrz, nrz_stb;
    dhs_crc_type     crc;
    logic [9:0]      faddr;
    logic            busy, operation_incomplete, data_late, skip_sector_error, sse_p, sync_p, irq, disp;
    logic [23:0]     timer;
    logic [1:0][7:0] buff;
    logic [1:0]      bcnt;
  } dhs_state_s_type;
  localparam dhs_state_s_type DHS_RESET = '0;
endpackage
`default_nettype wire

//--- dhs_core.sv
// Header search, address compare and write start sequencer
`timescale 1ns/100ps
`default_nettype none
module dhs_core #(
  parameter int TIMEOUT_CYC = dhs_pkg::TIMEOUT_CYC  // Function timer cycles
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_start,
  input  wire logic [2:0]            i_function_code,
  input  wire logic                  i_interrupt_enable,
  input  wire logic                  i_skip_sector_inhibit,
  input  wire logic [15:0]           i_disk_address,
  input  wire logic                  i_fifo_full,
  input  wire logic                  i_crc_error,
  input  wire logic [7:0]            i_wr_byte,
  input  wire logic                  i_wr_valid,
  output logic                       o_wr_ready,
  input  wire logic                  i_drive_servo_clock,
  input  wire logic                  i_drive_read_clock,
  input  wire logic                  i_drive_read_data,
  input  wire logic                  i_sector_start_pulse,
  output logic                       o_read_gate,
  output logic                       o_write_gate,
  output logic                       o_drive_write_data,
  output logic                       o_nrz_data,
  output logic                       o_nrz_strobe,
  output dhs_pkg::dhs_crc_type       o_crc,
  output dhs_pkg::dhs_clk_type       o_current_clock,
  output dhs_pkg::dhs_clk_type       o_sequence_clock,
  output logic [7:0]                 o_sequencer_constant,
  output logic                       o_sync_found,
  output logic                       o_compare_agree,
  output logic                       o_skip_sector_error,
  output logic                       o_skip_sector_status,
  output logic                       o_operation_incomplete,
  output logic                       o_data_late,
  output logic                       o_controller_ready,
  output logic                       o_interrupt_request,
  output logic                       o_dispatch,
  output logic [15:0]                o_disk_address,
  output logic [9:0]                 o_fifo_addr
);
  dhs_pkg::dhs_state_s_type s_q, s_d; // All state, current and next
  logic srv_e, rdc_e, sec_e;          // Synchronised rising edges
  logic rdd;                          // Synchronised read data

  // Edges seen only on second synchroniser stage
  assign srv_e = s_q.srv[1] & ~s_q.srv_p;
  assign rdc_e = s_q.rdc[1] & ~s_q.rdc_p;
  assign sec_e = s_q.sec[1] & ~s_q.sec_p;
  assign rdd   = s_q.rdd[1];

  // Address bit lined up with header bit i
  function automatic logic addr_bit(input logic [15:0] dar, input logic [5:0] i);
    logic r;
    r = 1'b0;
    if (i < 6'h05)
      r = dar[4'(i)];                       // Sector field
    else if (i >= 6'h08 && i < 6'h0B)
      r = dar[4'(i - 6'h03)];               // Head field
    else if (i >= 6'h10 && i < 6'h18)
      r = dar[4'(i - 6'h08)];               // Cylinder field
    return r;
  endfunction

  // Return to the CPU clock and report completion
  function automatic dhs_pkg::dhs_state_s_type finish(input dhs_pkg::dhs_state_s_type s);
    dhs_pkg::dhs_state_s_type r;
    r = s;
    r.cur = dhs_pkg::CK_CPU;
    r.seq = dhs_pkg::CK_CPU;
    r.rgate = 1'b0;
    r.wgate = 1'b0;
    r.crc.enable = 1'b0;
    r.crc.load = 1'b0;
    r.busy = 1'b0;
    r.irq = s.ie;
    r.st = dhs_pkg::ST_IDLE;
    return r;
  endfunction

  // Next-state logic of the whole block
  always_comb
  begin
    logic       pop;  // Buffer head consumed
    logic       push; // Buffer accepts a byte
    logic [1:0] left; // Count after pop
    pop = 1'b0;
    push = i_wr_valid && (s_q.bcnt != dhs_pkg::BUF_DEPTH);
    left = 2'h0;
    s_d = s_q;
    // Pin synchronisers
    s_d.srv = {s_q.srv[0], i_drive_servo_clock};
    s_d.rdc = {s_q.rdc[0], i_drive_read_clock};
    s_d.rdd = {s_q.rdd[0], i_drive_read_data};
    s_d.sec = {s_q.sec[0], i_sector_start_pulse};
    s_d.srv_p = s_q.srv[1];
    s_d.rdc_p = s_q.rdc[1];
    s_d.sec_p = s_q.sec[1];
    // Pulses default low
    s_d.nrz_stb = 1'b0;
    s_d.crc.clear = 1'b0;
    s_d.crc.compare = 1'b0;
    s_d.sync_p = 1'b0;
    s_d.sse_p = 1'b0;
    s_d.disp = 1'b0;
    // Function timer runs while busy
    if (s_q.busy && s_q.timer != 24'h000000)
      s_d.timer = s_q.timer - 24'h000001;
    if (s_q.st != dhs_pkg::ST_IDLE && s_q.st < dhs_pkg::ST_FIFO && s_q.timer == 24'h000000)
    begin
      // Search gave up: incomplete, back to CPU
      s_d.operation_incomplete = 1'b1;
      s_d = finish(s_d);
    end
    else
    begin
      unique case (s_q.st)
        dhs_pkg::ST_IDLE:
          if (i_start)
          begin
            // Latch control word, timer restarts
            s_d.fc = i_function_code;
            s_d.ie = i_interrupt_enable;
            s_d.inh = i_skip_sector_inhibit;
            s_d.dar = i_disk_address;
            s_d.timer = 24'(TIMEOUT_CYC);
            s_d.busy = 1'b1;
            s_d.operation_incomplete = 1'b0;
            s_d.data_late = 1'b0;
            s_d.skip_sector_error = 1'b0;
            s_d.irq = 1'b0;
            s_d.cur = dhs_pkg::CK_SERVO;
            s_d.seq = dhs_pkg::CK_SERVO;
            s_d.st = dhs_pkg::ST_WSEC;
          end
        dhs_pkg::ST_WSEC:
          if (sec_e)
          begin
            // Sector leading edge seen
            s_d.cnt = 7'h00;
            s_d.st = dhs_pkg::ST_GLITCH;
          end
        dhs_pkg::ST_GLITCH:
          if (srv_e)
          begin
            if (s_q.cnt == dhs_pkg::GLITCH_PLS - 7'h01)
            begin
              // Glitch zone passed, raise read gate
              s_d.rgate = 1'b1;
              s_d.crc.clear = 1'b1;
              s_d.agree = 1'b0;
              s_d.cnt = 7'h00;
              s_d.st = dhs_pkg::ST_PHASE;
            end
            else
              s_d.cnt = s_q.cnt + 7'h01;
          end
        dhs_pkg::ST_PHASE:
          if (srv_e)
          begin
            if (s_q.cnt == dhs_pkg::PHASE_PLS - 7'h01)
            begin
              // Lock reached, prepare sync hunt
              s_d.shreg = 8'h00;
              s_d.sconst = dhs_pkg::SYNC_BYTE;
              s_d.cur = dhs_pkg::CK_READ;   // Sequence clock stays servo
              s_d.st = dhs_pkg::ST_HUNT;
            end
            else
              s_d.cnt = s_q.cnt + 7'h01;
          end
        dhs_pkg::ST_HUNT:
          if (rdc_e)
          begin
            // Stalled here until pattern seen, incoming bit 0 first
            s_d.shreg = {rdd, s_q.shreg[7:1]};
            if ({rdd, s_q.shreg[7:1]} == s_q.sconst)
            begin
              s_d.sync_p = 1'b1;
              s_d.seq = dhs_pkg::CK_READ;
              s_d.crc.enable = 1'b1;
              s_d.agree = 1'b1;
              s_d.skip = 1'b0;
              s_d.bits = 6'h00;
              s_d.st = dhs_pkg::ST_HDR;
            end
          end
        dhs_pkg::ST_HDR:
          if (rdc_e)
          begin
            s_d.nrz = rdd;                  // Header bit onto NRZ bus
            s_d.nrz_stb = 1'b1;
            // Masked bitwise compare
            if (dhs_pkg::HDR_MASK[5'(s_q.bits)] && rdd != addr_bit(s_q.dar, s_q.bits))
              s_d.agree = 1'b0;
            if (5'(s_q.bits) == dhs_pkg::SKIP_POS && !s_q.inh)
              s_d.skip = rdd;
            if (s_q.bits == dhs_pkg::HDR_LAST)
            begin
              s_d.crc.enable = 1'b0;
              s_d.bits = 6'h00;
              s_d.st = dhs_pkg::ST_CHECK;
            end
            else
              s_d.bits = s_q.bits + 6'h01;
          end
        dhs_pkg::ST_CHECK:
          if (!s_q.agree)
          begin
            // No match: servo clock, next sector
            s_d.cur = dhs_pkg::CK_SERVO;
            s_d.seq = dhs_pkg::CK_SERVO;
            s_d.rgate = 1'b0;
            s_d.st = dhs_pkg::ST_WSEC;
          end
          else if (s_q.skip && !s_q.inh)
          begin
            // Displaced sector: flag, bump sector, retry
            s_d.skip_sector_error = 1'b1;
            s_d.sse_p = 1'b1;
            s_d.dar[4:0] = s_q.dar[4:0] + 5'h01;
            s_d.cur = dhs_pkg::CK_SERVO;
            s_d.seq = dhs_pkg::CK_SERVO;
            s_d.rgate = 1'b0;
            s_d.st = dhs_pkg::ST_WSEC;
          end
          else
          begin
            s_d.crc.load = 1'b1;
            s_d.st = dhs_pkg::ST_HCRC;
          end
        dhs_pkg::ST_HCRC:
          if (rdc_e)
          begin
            s_d.nrz = rdd;
            s_d.nrz_stb = 1'b1;
            if (s_q.bits == dhs_pkg::CRC_LAST)
            begin
              s_d.crc.load = 1'b0;
              s_d.crc.compare = 1'b1;
              s_d.st = dhs_pkg::ST_CRCCMP;
            end
            else
              s_d.bits = s_q.bits + 6'h01;
          end
        dhs_pkg::ST_CRCCMP:
          // Verdict is read one cycle after the compare pulse
          if (!s_q.crc.compare)
          begin
            if (i_crc_error)
            begin
              s_d.operation_incomplete = 1'b1;
              s_d = finish(s_d);
            end
            else
            begin
              s_d.crc.clear = 1'b1;
              if (s_q.fc == dhs_pkg::FC_WRITE)
              begin
                s_d.cur = dhs_pkg::CK_SERVO;
                s_d.seq = dhs_pkg::CK_SERVO;
                s_d.st = dhs_pkg::ST_FIFO;
              end
              else
              begin
                // Read and write check flows live elsewhere
                s_d.disp = 1'b1;
                s_d.st = dhs_pkg::ST_IDLE;
              end
            end
          end
        dhs_pkg::ST_FIFO:
          if (!i_fifo_full)
          begin
            // Buffer not filled in time
            s_d.data_late = 1'b1;
            s_d.agree = 1'b0;
            s_d = finish(s_d);
          end
          else
          begin
            s_d.rgate = 1'b0;
            s_d.cnt = 7'h00;
            s_d.st = dhs_pkg::ST_WGDLY;
          end
        dhs_pkg::ST_WGDLY:
          if (srv_e)
          begin
            if (s_q.cnt == dhs_pkg::WG_DLY_PLS - 7'h01)
            begin
              s_d.wgate = 1'b1;
              s_d.wdata = 1'b0;             // Gap low from the first gated cell
              s_d.faddr = 10'h000;
              s_d.shreg = 8'h00;
              s_d.cnt = 7'h00;
              s_d.st = dhs_pkg::ST_GAP;
            end
            else
              s_d.cnt = s_q.cnt + 7'h01;
          end
        dhs_pkg::ST_GAP:
          if (srv_e)
          begin
            s_d.wdata = 1'b0;
            if (s_q.cnt == dhs_pkg::GAP_BITS - 7'h01)
            begin
              s_d.shreg = dhs_pkg::SYNC_BYTE;
              s_d.bits = 6'h00;
              s_d.st = dhs_pkg::ST_SYNCO;
            end
            else
              s_d.cnt = s_q.cnt + 7'h01;
          end
        dhs_pkg::ST_SYNCO, dhs_pkg::ST_DATA:
          if (srv_e && s_q.bits > dhs_pkg::BYTE_LAST)
            // Final cell written in full, gate may drop now
            s_d = finish(s_d);
          else if (srv_e)
          begin
            // Formatter samples bit 0 of shifter
            s_d.wdata = s_q.shreg[0];
            s_d.nrz = s_q.shreg[0];
            s_d.nrz_stb = 1'b1;
            s_d.shreg = {1'b0, s_q.shreg[7:1]};
            if (s_q.bits == dhs_pkg::BYTE_LAST)
            begin
              s_d.bits = 6'h00;
              if (s_q.st == dhs_pkg::ST_DATA && s_q.faddr == dhs_pkg::DATA_BYTES)
                s_d.bits = dhs_pkg::BYTE_LAST + 6'h01; // Hold gate one more cell for the last bit
              else if (s_q.bcnt == 2'h0)
              begin
                // Buffer ran dry, word would be lost
                s_d.data_late = 1'b1;
                s_d = finish(s_d);
              end
              else
              begin
                s_d.shreg = s_q.buff[0];
                pop = 1'b1;
                s_d.faddr = s_q.faddr + 10'h001;
                s_d.crc.enable = 1'b1;
                s_d.st = dhs_pkg::ST_DATA;
              end
            end
            else
              s_d.bits = s_q.bits + 6'h01;
          end
        default:
          s_d = finish(s_d);
      endcase
    end
    // Two-entry byte buffer, head at index 0
    left = s_q.bcnt - {1'b0, pop};
    if (pop)
      s_d.buff[0] = s_q.buff[1];
    if (push)
      s_d.buff[left[0]] = i_wr_byte;
    s_d.bcnt = left + {1'b0, push};
  end

  // State register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_q <= dhs_pkg::DHS_RESET;
    else
      s_q <= s_d;
  end

  // Outputs straight from state
  assign o_wr_ready = (s_q.bcnt != dhs_pkg::BUF_DEPTH);
  assign o_read_gate = s_q.rgate;
  assign o_write_gate = s_q.wgate;
  assign o_drive_write_data = s_q.wdata;
  assign o_nrz_data = s_q.nrz;
  assign o_nrz_strobe = s_q.nrz_stb;
  assign o_crc = s_q.crc;
  assign o_current_clock = s_q.cur;
  assign o_sequence_clock = s_q.seq;
  assign o_sequencer_constant = s_q.sconst;
  assign o_sync_found = s_q.sync_p;
  assign o_compare_agree = s_q.agree;
  assign o_skip_sector_error = s_q.sse_p;
  assign o_skip_sector_status = s_q.skip_sector_error;
  assign o_operation_incomplete = s_q.operation_incomplete;
  assign o_data_late = s_q.data_late;
  assign o_controller_ready = ~s_q.busy;
  assign o_interrupt_request = s_q.irq;
  assign o_dispatch = s_q.disp;
  assign o_disk_address = s_q.dar;
  assign o_fifo_addr = s_q.faddr;

  // Checks on the sequence
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence hunt_done;
    s_q.st == dhs_pkg::ST_HUNT ##1 s_q.st == dhs_pkg::ST_HDR;
  endsequence
  sequence no_match;
    s_q.st == dhs_pkg::ST_CHECK && !s_q.agree && s_q.timer != 24'h000000;
  endsequence
  hunt_stall_a: assert property (s_q.st == dhs_pkg::ST_HUNT |->
    s_q.cur == dhs_pkg::CK_READ && s_q.seq != dhs_pkg::CK_READ) else $error("sequence clock not held");
  sync_resume_a: assert property (hunt_done |-> o_sync_found &&
    s_q.seq == dhs_pkg::CK_READ && s_q.crc.enable) else $error("no resume on sync");
  compare_agree_retry_a: assert property (no_match |=> s_q.st == dhs_pkg::ST_WSEC &&
    s_q.cur == dhs_pkg::CK_SERVO && s_q.seq == dhs_pkg::CK_SERVO) else $error("bad retry");
  skip_error_a: assert property (o_skip_sector_error |-> o_skip_sector_status &&
    s_q.dar[4:0] == $past(s_q.dar[4:0]) + 5'h01 && !$past(s_q.inh)) else $error("bad skip");
  crc_fail_a: assert property (s_q.st == dhs_pkg::ST_CRCCMP && !s_q.crc.compare && i_crc_error |=>
    o_operation_incomplete && o_controller_ready && s_q.cur == dhs_pkg::CK_CPU
    && o_interrupt_request == s_q.ie) else $error("bad crc fail");
  late_data_a: assert property (s_q.st == dhs_pkg::ST_FIFO && !i_fifo_full |=>
    o_data_late && !o_compare_agree && o_controller_ready) else $error("bad data late");
  gap_zero_a: assert property (s_q.st == dhs_pkg::ST_GAP |-> ##1
    o_write_gate && !o_read_gate && !o_drive_write_data) else $error("gap not zero");
  write_start_a: assert property ($rose(o_write_gate) |->
    $past(s_q.st) == dhs_pkg::ST_WGDLY && o_fifo_addr == 10'h000) else $error("bad write start");
endmodule
`default_nettype wire

//--- dhs_drive_model.sv
// Drive model: servo clock, sector marks and header frames
`timescale 1ns/100ps
`default_nettype none
module dhs_drive_model #(
  parameter int SECTOR_NS = 50000  // Sector mark spacing
) (
  input  wire logic        i_read_gate,
  input  wire logic [31:0] i_header,
  output logic             o_servo_clock,
  output logic             o_read_clock,
  output logic             o_read_data,
  output logic             o_sector_pulse
);
  logic [63:0] frame;  // Gap zeros, sync, header, check bits
  // Idle levels
  initial
  begin
    o_servo_clock = 1'b0;
    o_read_clock = 1'b0;
    o_read_data = 1'b0;
    o_sector_pulse = 1'b0;
  end
  // Servo clock runs free
  always #80 o_servo_clock = ~o_servo_clock;
  // One microsecond sector marks
  always
  begin
    #(SECTOR_NS - 1000) o_sector_pulse = 1'b1;
    #1000 o_sector_pulse = 1'b0;
  end
  // Frame starts after the lock wait, so the hunt sees gap zeros first
  always @(posedge i_read_gate)
  begin
    repeat (100) @(posedge o_servo_clock);
    frame = {16'hC35A, i_header, 8'h19, 8'h00};
    for (int i = 0; i < 64; i++)
    begin
      o_read_data = frame[i];
      #40 o_read_clock = 1'b1;
      #80 o_read_clock = 1'b0;
      #40;
    end
    // Released line: inverse, never a stale bit
    o_read_data = ~o_read_data;
  end
endmodule
`default_nettype wire

//--- dhs_core_bench.sv
// Self-checking bench of the header search and write start sequencer
`timescale 1ns/100ps
`default_nettype none
module dhs_core_bench;
  logic        i_clk, i_resetn, i_start, i_interrupt_enable, i_skip_sector_inhibit, i_fifo_full;
  logic        i_crc_error, i_wr_valid, o_wr_ready, i_drive_servo_clock, i_drive_read_clock;
  logic        i_drive_read_data, i_sector_start_pulse, o_read_gate, o_write_gate, o_drive_write_data;
  logic        o_nrz_data, o_nrz_strobe, o_compare_agree, o_skip_sector_error, o_skip_sector_status;
  logic        o_operation_incomplete, o_data_late, o_controller_ready, o_interrupt_request, o_dispatch, b;
  logic        o_sync_found;
  logic [2:0]  i_function_code;
  logic [7:0]  i_wr_byte, o_sequencer_constant;
  logic [9:0]  o_fifo_addr;
  logic [15:0] i_disk_address, o_disk_address, da;
  logic [31:0] hdr;       // Header the drive sends
  logic        exp_q[$];  // Expected write bits
  int          error_cnt = 0, samples_checked = 0, seed = 51909, gcnt = 0;
  dhs_pkg::dhs_clk_type o_current_clock, o_sequence_clock;
  dhs_pkg::dhs_crc_type o_crc;

  dhs_core #(.TIMEOUT_CYC(20000)) u_dut (.i_clk, .i_resetn, .i_start, .i_function_code,
    .i_interrupt_enable, .i_skip_sector_inhibit, .i_disk_address, .i_fifo_full, .i_crc_error,
    .i_wr_byte, .i_wr_valid, .o_wr_ready, .i_drive_servo_clock, .i_drive_read_clock, .i_drive_read_data,
    .i_sector_start_pulse, .o_read_gate, .o_write_gate, .o_drive_write_data, .o_nrz_data, .o_nrz_strobe,
    .o_crc, .o_current_clock, .o_sequence_clock, .o_sequencer_constant, .o_sync_found,
    .o_compare_agree, .o_skip_sector_error, .o_skip_sector_status, .o_operation_incomplete, .o_data_late,
    .o_controller_ready, .o_interrupt_request, .o_dispatch, .o_disk_address, .o_fifo_addr);
  dhs_drive_model u_drive (.i_read_gate(o_read_gate), .i_header(hdr), .o_servo_clock(i_drive_servo_clock),
    .o_read_clock(i_drive_read_clock), .o_read_data(i_drive_read_data), .o_sector_pulse(i_sector_start_pulse));

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // Header word; unused bits get random junk, flag bit comes from skip
  function automatic logic [31:0] hdr_of(input logic [15:0] a, input logic skip);
    logic [31:0] junk;
    junk = $random(seed);
    return (junk & ~dhs_pkg::HDR_MASK & 32'hFFFF_BFFF) | {8'h00, a[15:8], 1'b0, skip, 3'h0, a[7:5], 3'h0, a[4:0]};
  endfunction

  task automatic do_reset();
    i_resetn = 1'b0;
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
  endtask

  // One function, up to finish or hand-off
  task automatic run(input logic [2:0] fc, input logic ie, input logic inh, input logic full, input logic ce);
    int n;
    @(negedge i_clk);
    i_function_code = fc;
    i_interrupt_enable = ie;
    i_skip_sector_inhibit = inh;
    i_fifo_full = full;
    i_crc_error = ce;
    i_disk_address = da;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    n = 0;
    while (o_controller_ready !== 1'b1 && o_dispatch !== 1'b1 && n < 60000)
    begin
      @(negedge i_clk);
      n++;
    end
    cmp(16'(n / 60000), 16'h0000);
  endtask

  // Flags {incomplete, late, irq, agree, skip status} and address
  task automatic fin(input logic [4:0] f, input logic [15:0] a);
    cmp({o_operation_incomplete, o_data_late, o_interrupt_request, o_compare_agree, o_skip_sector_status}, f);
    cmp(o_disk_address, a);
  endtask

  // Bytes with random pauses; a full buffer holds them back
  task automatic feed();
    logic [7:0] v;
    for (int k = 0; k < 512; k++)
    begin
      v = 8'($random(seed));
      @(negedge i_clk);
      i_wr_byte = v;
      i_wr_valid = 1'b1;
      while (o_wr_ready !== 1'b1)
        @(negedge i_clk);
      for (int j = 0; j < 8; j++)
        exp_q.push_back(v[j]);
      if ($random(seed) % 3 == 0)
      begin
        @(negedge i_clk);
        i_wr_valid = 1'b0;
      end
    end
    @(negedge i_clk);
    i_wr_valid = 1'b0;
  endtask

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A flagged sector is followed by the displaced one, unflagged
  always @(negedge i_clk)
    if (o_skip_sector_error === 1'b1)
      hdr = hdr_of(da + 16'h0001, 1'b0);

  // Gap stays low; each strobed bit is the oldest expected one
  always @(negedge i_clk)
  begin
    gcnt <= (o_write_gate === 1'b1) ? gcnt + 1 : 0;
    // Sync found: sequence clock follows the read clock, check word runs
    if (o_sync_found === 1'b1)
      cmp({o_sequence_clock, o_crc.enable, o_sequencer_constant},
          {dhs_pkg::CK_READ, 1'b1, dhs_pkg::SYNC_BYTE});
    if (o_write_gate === 1'b1 && o_nrz_strobe === 1'b1)
    begin
      b = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx;
      cmp({o_drive_write_data, o_nrz_data}, {b, b});
    end
    else if (o_write_gate === 1'b1 && gcnt < 900)
      cmp(o_drive_write_data, 1'b0);
  end

  // Hang guard, about 95k cycles; a clean run ends near 86k
  initial
  begin
    #1_900_000;
    error_cnt++;
    results();
  end

  initial
  begin
    {i_clk, i_start, i_interrupt_enable, i_skip_sector_inhibit, i_fifo_full, i_crc_error, i_wr_valid} = '0;
    {i_function_code, i_wr_byte, i_disk_address, da, hdr} = '0;
    do_reset();
    // Wrong cylinder: search runs out
    da = 16'h5B23;
    hdr = hdr_of(16'h5A23, 1'b0);
    run(3'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    fin(5'b10100, da);
    // Flagged sector, then check word error
    da = 16'h5A23;
    hdr = hdr_of(da, 1'b1);
    run(3'h1, 1'b0, 1'b0, 1'b0, 1'b1);
    fin(5'b10011, 16'h5A24);
    // Flag inhibited
    da = 16'h3C41;
    hdr = hdr_of(da, 1'b1);
    run(3'h1, 1'b1, 1'b1, 1'b0, 1'b1);
    fin(5'b10110, da);
    // Write with empty buffer store
    da = 16'($random(seed));
    hdr = hdr_of(da, 1'b0);
    run(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    fin(5'b01100, da);
    cmp(o_current_clock, dhs_pkg::CK_CPU);
    // Other codes hand off
    for (int f = 0; f < 8; f++)
      if (f != 1)
      begin
        da = 16'($random(seed));
        hdr = hdr_of(da, 1'b1);
        run(3'(f), 1'b0, 1'b1, 1'b0, 1'b0);
        cmp({o_dispatch, o_controller_ready}, 2'b10);
        do_reset();
      end
    // Full write
    da = 16'($random(seed));
    hdr = hdr_of(da, 1'b0);
    for (int j = 0; j < 8; j++)
      exp_q.push_back(dhs_pkg::SYNC_BYTE[j]);
    fork
      run(dhs_pkg::FC_WRITE, 1'b1, 1'b0, 1'b1, 1'b0);
      begin
        wait (o_controller_ready === 1'b0);
        feed();
      end
    join
    fin(5'b00110, da);
    cmp({o_fifo_addr, o_write_gate, o_read_gate}, {dhs_pkg::DATA_BYTES, 2'b00});
    cmp(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
